// File: core/pbaf_port_b_mux.sv
// Pin override logic for the eight pins of general-purpose port B.
`timescale 1ns/100ps
`include "pbaf_defines.svh"

module pbaf_port_b_mux #(
  parameter int NUM_PINS = `PBAF_NUM_PINS
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Port registers and global controls.
  input wire logic [NUM_PINS-1:0] portDir,
  input wire logic [NUM_PINS-1:0] portOut,
  input wire logic globalPullupDisable,
  input wire logic sleepActive,
  // Timer compare outputs and their enables.
  input wire logic timer2CompareAEn,
  input wire logic timer2CompareAOut,
  input wire logic timer1CompareBEn,
  input wire logic timer1CompareBOut,
  input wire logic timer1CompareAEn,
  input wire logic timer1CompareAOut,
  input wire logic timer0CompareAEn,
  input wire logic timer0CompareAOut,
  // SPI unit configuration and outgoing data.
  input wire logic spiUnitEnable,
  input wire logic spiMasterSelect,
  input wire logic spiSlaveTxData,
  input wire logic spiMasterTxData,
  input wire logic spiSckOut,
  // Pin-change controls.
  input wire logic [NUM_PINS-1:0] pinChangeMask,
  input wire logic pinChangeGroup1Enable,
  // Pads.
  input wire logic [NUM_PINS-1:0] padIn,
  output logic [NUM_PINS-1:0] padOut,
  output logic [NUM_PINS-1:0] padOe,
  output logic [NUM_PINS-1:0] padPullup,
  output logic [NUM_PINS-1:0] padInBufEn,
  // Inputs returned to the peripherals.
  output logic [NUM_PINS-1:0] pinChangeSrc,
  output logic spiMasterRxData,
  output logic spiSlaveRxData,
  output logic spiSckIn,
  output logic spiSlaveSelect_b,
  output logic spiSlaveActive
);

  if (NUM_PINS != `PBAF_NUM_PINS) begin : gNumPinsCheck
    $error("pbaf_port_b_mux serves exactly eight pins");
  end

  pbaf_pkg::pbaf_spi_mode_e spiMode;
  pbaf_pkg::pbaf_pins_t pullOvrEn;
  pbaf_pkg::pbaf_pins_t pullOvrVal;
  pbaf_pkg::pbaf_pins_t dirOvrEn;
  pbaf_pkg::pbaf_pins_t dirOvrVal;
  pbaf_pkg::pbaf_pins_t valOvrEn;
  pbaf_pkg::pbaf_pins_t valOvrVal;
  pbaf_pkg::pbaf_pins_t bufOvrEn;
  pbaf_pkg::pbaf_pins_t bufOvrVal;
  pbaf_pkg::pbaf_pins_t padMeta_q;
  pbaf_pkg::pbaf_pins_t padSync_q;
  pbaf_pkg::pbaf_pins_t padOut_d;
  pbaf_pkg::pbaf_pins_t padOut_q;
  pbaf_pkg::pbaf_pins_t padOe_d;
  pbaf_pkg::pbaf_pins_t padOe_q;
  pbaf_pkg::pbaf_pins_t padPullup_d;
  pbaf_pkg::pbaf_pins_t padPullup_q;
  pbaf_pkg::pbaf_pins_t padInBufEn_d;
  pbaf_pkg::pbaf_pins_t padInBufEn_q;
  pbaf_pkg::pbaf_pins_t pinChangeSrc_d;
  pbaf_pkg::pbaf_pins_t pinChangeSrc_q;
  pbaf_pkg::pbaf_pins_t digIn;
  logic spiMasterRxData_d;
  logic spiMasterRxData_q;
  logic spiSlaveRxData_d;
  logic spiSlaveRxData_q;
  logic spiSckIn_d;
  logic spiSckIn_q;
  logic spiSlaveSelect_b_d;
  logic spiSlaveSelect_b_q;
  logic spiSlaveActive_d;
  logic spiSlaveActive_q;

  // Pad inputs come from outside the clock domain; only the second stage is read.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      padMeta_q <= `PBAF_RST_PINS;
      padSync_q <= `PBAF_RST_PINS;
    end else begin
      padMeta_q <= padIn;
      padSync_q <= padMeta_q;
    end
  end

  // Overrides and next returned inputs, from peripheral, port and synchronized pad state in one cycle.
  always_comb begin
    if (!spiUnitEnable) begin
      spiMode = pbaf_pkg::PBAF_SPI_OFF;
    end else if (spiMasterSelect) begin
      spiMode = pbaf_pkg::PBAF_SPI_MASTER;
    end else begin
      spiMode = pbaf_pkg::PBAF_SPI_SLAVE;
    end

    pullOvrEn = `PBAF_RST_PINS;
    pullOvrVal = `PBAF_RST_PINS;
    dirOvrEn = `PBAF_RST_PINS;
    dirOvrVal = `PBAF_RST_PINS;
    valOvrEn = `PBAF_RST_PINS;
    valOvrVal = `PBAF_RST_PINS;

    valOvrEn[`PBAF_PIN_T2A] = timer2CompareAEn;
    valOvrVal[`PBAF_PIN_T2A] = timer2CompareAOut;
    valOvrEn[`PBAF_PIN_T1B] = timer1CompareBEn;
    valOvrVal[`PBAF_PIN_T1B] = timer1CompareBOut;
    valOvrEn[`PBAF_PIN_T1A] = timer1CompareAEn;
    valOvrVal[`PBAF_PIN_T1A] = timer1CompareAOut;
    valOvrEn[`PBAF_PIN_T0A] = timer0CompareAEn;
    valOvrVal[`PBAF_PIN_T0A] = timer0CompareAOut;

    case (spiMode)
      pbaf_pkg::PBAF_SPI_MASTER: begin
        dirOvrEn[`PBAF_PIN_CIPO] = 1'h1;
        pullOvrEn[`PBAF_PIN_CIPO] = 1'h1;
        valOvrEn[`PBAF_PIN_COPI] = 1'h1;
        valOvrVal[`PBAF_PIN_COPI] = spiMasterTxData;
        valOvrEn[`PBAF_PIN_SCK] = 1'h1;
        valOvrVal[`PBAF_PIN_SCK] = spiSckOut;
      end
      pbaf_pkg::PBAF_SPI_SLAVE: begin
        valOvrEn[`PBAF_PIN_CIPO] = 1'h1;
        valOvrVal[`PBAF_PIN_CIPO] = spiSlaveTxData;
        dirOvrEn[`PBAF_PIN_COPI] = 1'h1;
        dirOvrEn[`PBAF_PIN_SCK] = 1'h1;
        dirOvrEn[`PBAF_PIN_SEL] = 1'h1;
        pullOvrEn[`PBAF_PIN_COPI] = 1'h1;
        pullOvrEn[`PBAF_PIN_SCK] = 1'h1;
        pullOvrEn[`PBAF_PIN_SEL] = 1'h1;
      end
      pbaf_pkg::PBAF_SPI_OFF: begin
        pullOvrEn = `PBAF_RST_PINS;
      end
      default: begin
        pullOvrEn = `PBAF_RST_PINS;
      end
    endcase

    pullOvrVal = portOut & {NUM_PINS{~globalPullupDisable}};

    bufOvrEn = pinChangeMask & {NUM_PINS{pinChangeGroup1Enable}};
    bufOvrVal = {NUM_PINS{1'h1}};

    // A disabled input buffer reads as zero, as a real Schmitt gate would.
    digIn = padSync_q & padInBufEn_q;
    pinChangeSrc_d = digIn;

    spiMasterRxData_d = digIn[`PBAF_PIN_CIPO];
    spiSlaveRxData_d = digIn[`PBAF_PIN_COPI];
    spiSckIn_d = digIn[`PBAF_PIN_SCK];
    spiSlaveSelect_b_d = digIn[`PBAF_PIN_SEL];
    spiSlaveActive_d = (spiMode == pbaf_pkg::PBAF_SPI_SLAVE) && !digIn[`PBAF_PIN_SEL];
  end

  // One selector per pin keeps the override priority identical on all eight pins.
  for (genvar i = 0; i < NUM_PINS; i++) begin : gPin
    pbaf_pin_select #(
      .PIN(i)
    ) pbaf_pin_select_i (
      .pullOvrEn(pullOvrEn[i]),
      .pullOvrVal(pullOvrVal[i]),
      .dirOvrEn(dirOvrEn[i]),
      .dirOvrVal(dirOvrVal[i]),
      .valOvrEn(valOvrEn[i]),
      .valOvrVal(valOvrVal[i]),
      .bufOvrEn(bufOvrEn[i]),
      .bufOvrVal(bufOvrVal[i]),
      .portDir(portDir[i]),
      .portOut(portOut[i]),
      .globalPullupDisable(globalPullupDisable),
      .sleepActive(sleepActive),
      .pullupNext(padPullup_d[i]),
      .oeNext(padOe_d[i]),
      .outNext(padOut_d[i]),
      .inBufEnNext(padInBufEn_d[i])
    );
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      padOut_q <= `PBAF_RST_PINS;
      padOe_q <= `PBAF_RST_PINS;
      padPullup_q <= `PBAF_RST_PINS;
      padInBufEn_q <= `PBAF_RST_PINS;
      pinChangeSrc_q <= `PBAF_RST_PINS;
      spiMasterRxData_q <= `PBAF_RST_BIT;
      spiSlaveRxData_q <= `PBAF_RST_BIT;
      spiSckIn_q <= `PBAF_RST_BIT;
      spiSlaveSelect_b_q <= `PBAF_RST_SEL_B;
      spiSlaveActive_q <= `PBAF_RST_BIT;
    end else begin
      padOut_q <= padOut_d;
      padOe_q <= padOe_d;
      padPullup_q <= padPullup_d;
      padInBufEn_q <= padInBufEn_d;
      pinChangeSrc_q <= pinChangeSrc_d;
      spiMasterRxData_q <= spiMasterRxData_d;
      spiSlaveRxData_q <= spiSlaveRxData_d;
      spiSckIn_q <= spiSckIn_d;
      spiSlaveSelect_b_q <= spiSlaveSelect_b_d;
      spiSlaveActive_q <= spiSlaveActive_d;
    end
  end

  // Every output is registered, so pad controls change one clock after their cause and returned inputs three clocks after a pad change.
  assign padOut = padOut_q;
  assign padOe = padOe_q;
  assign padPullup = padPullup_q;
  assign padInBufEn = padInBufEn_q;
  assign pinChangeSrc = pinChangeSrc_q;
  assign spiMasterRxData = spiMasterRxData_q;
  assign spiSlaveRxData = spiSlaveRxData_q;
  assign spiSckIn = spiSckIn_q;
  assign spiSlaveSelect_b = spiSlaveSelect_b_q;
  assign spiSlaveActive = spiSlaveActive_q;

endmodule

// Per-pin choice between a peripheral's overrides and the plain port bits.
module pbaf_pin_select #(
  parameter int PIN = 0
) (
  // Overrides from the owning peripheral.
  input wire logic pullOvrEn,
  input wire logic pullOvrVal,
  input wire logic dirOvrEn,
  input wire logic dirOvrVal,
  input wire logic valOvrEn,
  input wire logic valOvrVal,
  input wire logic bufOvrEn,
  input wire logic bufOvrVal,
  // Plain port controls.
  input wire logic portDir,
  input wire logic portOut,
  input wire logic globalPullupDisable,
  input wire logic sleepActive,
  // Next pad controls, registered by the caller.
  output logic pullupNext,
  output logic oeNext,
  output logic outNext,
  output logic inBufEnNext
);

  if (PIN < 0 || PIN >= `PBAF_NUM_PINS) begin : gPinCheck
    $error("pbaf_pin_select pin index out of range");
  end

  always_comb begin
    pullupNext = pullOvrEn ? pullOvrVal : (!portDir && portOut && !globalPullupDisable);
    oeNext = dirOvrEn ? dirOvrVal : portDir;
    outNext = valOvrEn ? valOvrVal : portOut;
    inBufEnNext = bufOvrEn ? bufOvrVal : !sleepActive;
  end

endmodule

// File: core/pbaf_defines.svh
// Constants for the port B alternate-function override block.
`ifndef PBAF_DEFINES_SVH
`define PBAF_DEFINES_SVH

`define PBAF_NUM_PINS 8
`define PBAF_PIN_T2A 3'h7
`define PBAF_PIN_T1B 3'h6
`define PBAF_PIN_T1A 3'h5
`define PBAF_PIN_T0A 3'h4
`define PBAF_PIN_CIPO 3'h3
`define PBAF_PIN_COPI 3'h2
`define PBAF_PIN_SCK 3'h1
`define PBAF_PIN_SEL 3'h0
`define PBAF_RST_PINS 8'h00
`define PBAF_RST_BIT 1'h0
`define PBAF_RST_SEL_B 1'h1

`endif

// File: core/pbaf_pkg.sv
// Types shared by the port B alternate-function override block.
`include "pbaf_defines.svh"
package pbaf_pkg;

  typedef logic [`PBAF_NUM_PINS-1:0] pbaf_pins_t;

  // Role the SPI unit gives the four lower pins.
  typedef enum logic [1:0] {
    PBAF_SPI_OFF = 2'b00,
    PBAF_SPI_SLAVE = 2'b01,
    PBAF_SPI_MASTER = 2'b10
  } pbaf_spi_mode_e;

endpackage

// File: bench/pbaf_port_b_monitor.sv
// Concurrent checks on the pins of the port B override block.
`timescale 1ns/100ps
module pbaf_port_b_monitor #(
  parameter int NUM_PINS = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Controls.
  input wire logic [NUM_PINS-1:0] portDir,
  input wire logic [NUM_PINS-1:0] portOut,
  input wire logic [NUM_PINS-1:0] pinChangeMask,
  input wire logic globalPullupDisable,
  input wire logic sleepActive,
  input wire logic pinChangeGroup1Enable,
  input wire logic timer2CompareAEn,
  input wire logic timer2CompareAOut,
  input wire logic timer1CompareBEn,
  input wire logic timer1CompareBOut,
  input wire logic spiUnitEnable,
  input wire logic spiMasterSelect,
  input wire logic spiSlaveTxData,
  input wire logic spiMasterTxData,
  input wire logic spiSckOut,
  // Results.
  input wire logic [NUM_PINS-1:0] padOut,
  input wire logic [NUM_PINS-1:0] padOe,
  input wire logic [NUM_PINS-1:0] padPullup,
  input wire logic [NUM_PINS-1:0] padInBufEn,
  input wire logic spiSlaveSelect_b,
  input wire logic spiSlaveActive
);
  wire logic spi_master_select = spiUnitEnable & spiMasterSelect;
  wire logic slv = spiUnitEnable & ~spiMasterSelect;
  wire logic [7:0] forced = {4'h0, spi_master_select, {3{slv}}};
  wire logic [7:0] pullExp = (forced | ~portDir) & portOut & {8{~globalPullupDisable}};
  wire logic [7:0] bufExp = (pinChangeMask & {8{pinChangeGroup1Enable}}) | {8{~sleepActive}};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  t2_value_a: assert property ($past(rst_b) && $past(timer2CompareAEn)
    |-> padOut[7] == $past(timer2CompareAOut)) else $error("Pin 7 value wrong.");
  t1b_value_a: assert property ($past(rst_b) && $past(timer1CompareBEn)
    |-> padOut[6] == $past(timer1CompareBOut)) else $error("Pin 6 value wrong.");
  master_pins_a: assert property ($past(rst_b) && $past(spi_master_select)
    |-> !padOe[3] && padOut[2:1] == $past({spiMasterTxData, spiSckOut}))
    else $error("Master pins wrong.");
  slave_pins_a: assert property ($past(rst_b) && $past(slv)
    |-> padOe[2:0] == 3'h0 && padOut[3] == $past(spiSlaveTxData)) else $error("Slave pins wrong.");
  pullup_value_a: assert property ($past(rst_b) |-> padPullup == $past(pullExp))
    else $error("Pull-up wrong.");
  inbuf_enable_a: assert property ($past(rst_b) |-> padInBufEn == $past(bufExp))
    else $error("Input buffer enable wrong.");
  plain_dir_a: assert property ($past(rst_b) && !$past(spiUnitEnable)
    |-> padOe == $past(portDir)) else $error("Direction wrong.");
  sel_value_a: assert property ($past(rst_b) |-> padOut[0] == $past(portOut[0]))
    else $error("Pin 0 value wrong.");
  slave_sel_a: assert property (spiSlaveActive |-> !spiSlaveSelect_b)
    else $error("Slave active while deselected.");
  cover property (spiSlaveActive);
  cover property ($past(rst_b) && $past(spi_master_select) && !padOe[3]);
  cover property (sleepActive && padInBufEn != 8'h00);
endmodule
bind pbaf_port_b_mux pbaf_port_b_monitor #(.NUM_PINS(NUM_PINS)) pbaf_port_b_monitor_i (.*);

// File: bench/pbaf_pad_model.sv
// Pad and outside-circuit model for the eight port B pins.
`timescale 1ns/100ps
module pbaf_pad_model (
  // Clock.
  input wire logic core_clk,
  // Pad controls from the block.
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] padPullup,
  // Outside drivers.
  input wire logic [7:0] extDrive,
  input wire logic [7:0] extEn,
  // Resolved pad level.
  output logic [7:0] padIn
);
  logic [7:0] padLast_q = 8'h00;
  always_ff @(posedge core_clk) begin
    padLast_q <= padIn;
  end
  // outside select drive
  // A floating pad flips every cycle so a stale level never passes for a real one.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      padIn[i] = padOe[i] ? padOut[i] : (extEn[i] ? extDrive[i] : (padPullup[i] | ~padLast_q[i]));
    end
  end
endmodule

// File: bench/tb_port_b_alternate_function_override.sv
// Self-checking bench for the port B override block.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_port_b_alternate_function_override;
  typedef struct packed {logic [29:0] in; logic [7:0] oe, po, pu;} pbaf_row_s;
  logic core_clk, rst_b, globalPullupDisable, sleepActive, spiUnitEnable, spiMasterSelect;
  logic pinChangeGroup1Enable, spiMasterRxData, spiSlaveRxData, spiSckIn;
  logic spiSlaveSelect_b, spiSlaveActive;
  logic [3:0] tEn, tOut;
  logic [2:0] tx;
  logic [7:0] portDir, portOut, pinChangeMask, padIn, padOut, padOe, padPullup;
  logic [7:0] padInBufEn, pinChangeSrc, extDrive, extEn;
  int checked = 0;
  int mismatches = 0;
  pbaf_row_s rows [8] = '{
    '{{3'h0, 8'hf0, 8'h3c, 4'h0, 4'hf, 3'h7}, 8'hf0, 8'h3c, 8'h0c},
    '{{3'h1, 8'h0f, 8'hff, 4'h0, 4'h0, 3'h0}, 8'h0f, 8'hff, 8'h00},
    '{{3'h0, 8'hff, 8'h00, 4'hf, 4'ha, 3'h0}, 8'hff, 8'ha0, 8'h00},
    '{{3'h0, 8'h0f, 8'ha0, 4'h5, 4'hf, 3'h0}, 8'h0f, 8'hf0, 8'ha0},
    '{{3'h6, 8'h0f, 8'h0b, 4'h0, 4'h0, 3'h6}, 8'h07, 8'h0d, 8'h08},
    '{{3'h4, 8'h0f, 8'h0e, 4'h0, 4'h0, 3'h1}, 8'h08, 8'h06, 8'h06},
    '{{3'h5, 8'h08, 8'h0f, 4'h0, 4'h0, 3'h4}, 8'h08, 8'h0f, 8'h00},
    '{{3'h2, 8'h08, 8'h01, 4'h0, 4'h0, 3'h7}, 8'h08, 8'h01, 8'h01}};
  pbaf_port_b_mux pbaf_port_b_mux_i (.core_clk, .rst_b, .portDir, .portOut,
    .globalPullupDisable, .sleepActive, .timer2CompareAEn(tEn[3]), .timer2CompareAOut(tOut[3]),
    .timer1CompareBEn(tEn[2]), .timer1CompareBOut(tOut[2]), .timer1CompareAEn(tEn[1]),
    .timer1CompareAOut(tOut[1]), .timer0CompareAEn(tEn[0]), .timer0CompareAOut(tOut[0]),
    .spiUnitEnable, .spiMasterSelect, .spiSlaveTxData(tx[2]), .spiMasterTxData(tx[1]),
    .spiSckOut(tx[0]), .pinChangeMask, .pinChangeGroup1Enable, .padIn, .padOut, .padOe,
    .padPullup, .padInBufEn, .pinChangeSrc, .spiMasterRxData, .spiSlaveRxData, .spiSckIn,
    .spiSlaveSelect_b, .spiSlaveActive);
  pbaf_pad_model pbaf_pad_model_i (.core_clk, .padOut, .padOe, .padPullup, .extDrive,
    .extEn, .padIn);
  always #2.5 core_clk = ~core_clk;
  task test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {core_clk, rst_b, sleepActive, pinChangeGroup1Enable, pinChangeMask, extDrive, extEn} = '0;
    {spiUnitEnable, spiMasterSelect, globalPullupDisable, portDir, portOut, tEn, tOut, tx} = '0;
    repeat (20) @(negedge core_clk);
    `CHK("padOe in reset", 8'h00, padOe)
    `CHK("select in reset", 1'h1, spiSlaveSelect_b)
    $display("reset hold test done");
    rst_b = 1'h1;
    foreach (rows[i]) begin
      {spiUnitEnable, spiMasterSelect, globalPullupDisable, portDir, portOut} = rows[i].in[29:11];
      {tEn, tOut, tx} = rows[i].in[10:0];
      @(negedge core_clk);
      `CHK("padOe", rows[i].oe, padOe)
      `CHK("padOut", rows[i].po, padOut)
      `CHK("padPullup", rows[i].pu, padPullup)
      $display("row %0d done", i);
    end
    {spiUnitEnable, portDir, sleepActive} = {9'h0, 1'h1};
    {pinChangeMask, pinChangeGroup1Enable} = {8'h81, 1'h1};
    {extEn, extDrive} = {8'hff, 8'h83};
    repeat (3) @(negedge core_clk);
    `CHK("padInBufEn sleep", 8'h81, padInBufEn)
    `CHK("pinChangeSrc", 8'h81, pinChangeSrc)
    pinChangeGroup1Enable = 1'h0;
    @(negedge core_clk);
    `CHK("padInBufEn off", 8'h00, padInBufEn)
    $display("sleep test done");
    {sleepActive, spiUnitEnable, spiMasterSelect, extDrive} = {3'h2, 8'h06};
    repeat (3) @(negedge core_clk);
    `CHK("slave active", 1'h1, spiSlaveActive)
    `CHK("slave rx", 1'h1, spiSlaveRxData)
    `CHK("sck in", 1'h1, spiSckIn)
    `CHK("select low", 1'h0, spiSlaveSelect_b)
    extDrive = 8'h07;
    repeat (3) @(negedge core_clk);
    `CHK("slave idle", 1'h0, spiSlaveActive)
    {spiMasterSelect, portDir, extDrive} = {1'h1, 8'hff, 8'h08};
    repeat (3) @(negedge core_clk);
    `CHK("master rx", 1'h1, spiMasterRxData)
    `CHK("master oe", 8'hf7, padOe)
    $display("spi test done");
    rst_b = 1'h0;
    #1;
    `CHK("padOe mid reset", 8'h00, padOe)
    $display("reset test done");
    test_done();
  end
endmodule
